/* File: src/tcc_timer_channels.sv */
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer_channels
  import tcc_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     clk1kIn,
  input  wire logic                     clk32kIn,
  input  wire logic                     timerClockPin,
  input  wire logic                     timerClockGatePin,
  input  wire logic [`TCC_NCH-1:0]      channelInputPin,
  output logic      [`TCC_NCH-1:0]      channelOutput,
  output logic      [`TCC_NCH-1:0]      channelOutputEn,
  output logic      [`TCC_NCH-1:0]      ccIrq,
  output logic      [`TCC_CNT_W-1:0]    counterValue
);
  import tcc_pkg::*;

  tcc_state_s                s;          // registered state
  tcc_state_s                next_s;     // next state
  logic                      wrEn;       // write access phase
  logic                      rdEn;       // read access phase
  logic [`TCC_NCH-1:0]       chRaw;      // selected pin per channel
  logic [`TCC_NCH-1:0]       chEdge;     // edge_selected_channel_input
  logic                      trig;       // slave controller trigger
  logic                      etrTick;    // resynchronised counter clock
  logic                      etrRaw;     // ext_trigger_input

  // filter length minus one; longer codes saturate at eight samples
  function automatic logic [3:0] filtLim(input logic [3:0] f);
    unique case (f)
      4'h0:    filtLim = 4'h0;
      4'h1:    filtLim = 4'h1;
      4'h2:    filtLim = 4'h3;
      default: filtLim = 4'h7;
    endcase
  endfunction : filtLim

  // edges per prescaler period minus one
  function automatic logic [2:0] pscLim(input logic [1:0] p);
    unique case (p)
      2'h0: pscLim = 3'h0;
      2'h1: pscLim = 3'h1;
      2'h2: pscLim = 3'h3;
      2'h3: pscLim = 3'h7;
    endcase
  endfunction : pscLim

  // zero-wait apb, accesses complete in the first access cycle
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & penable & ~pwrite;
  assign counterValue = s.cnt;

  // trigger source mux
  always_comb
  begin
    unique case (s.extSel)
      `TCC_SRC_PCLK: etrRaw = s.pclkDiv;
      `TCC_SRC_1K:   etrRaw = clk1kIn;
      `TCC_SRC_32K:  etrRaw = clk32kIn;
      `TCC_SRC_PIN:  etrRaw = timerClockPin & (~s.gateEn | timerClockGatePin);
    endcase
  end

  // counter tick is an edge of the second sync stage only
  assign etrTick = s.sync2 ^ s.sync2d;

  // per-channel pin routing and edge detection
  always_comb
  begin
    for (int i = 0; i < `TCC_NCH; i++)
    begin
      // neighbour routing lets channel 1 capture from pin 0
      chRaw[i] = (s.ch[i].dirSel == `TCC_DIR_NEIGH) ? channelInputPin[(i + 1) % `TCC_NCH]
                                                    : channelInputPin[i];
      // polarity picks rising or falling filtered edge
      chEdge[i] = s.ch[i].ccp ? (s.ch[i].prevF & ~s.ch[i].filt)
                              : (~s.ch[i].prevF & s.ch[i].filt);
      ccIrq[i] = s.ch[i].flag & s.ch[i].ie;
      channelOutput[i] = s.ch[i].outRef ^ s.ch[i].ccp;
      channelOutputEn[i] = (s.ch[i].dirSel == `TCC_DIR_OUT) & s.ch[i].cce;
    end
  end

  // slave trigger: either channel edge, by trigger select
  assign trig = (s.ts == `TCC_TS_CH0) ? chEdge[0] :
                (s.ts == `TCC_TS_CH1) ? chEdge[1] : 1'b0;

  // register read mux, answer is combinational from flops
  always_comb
  begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    unique case (paddr)
      `TCC_OFS_CTRL:   prdata[0] = s.cen;
      `TCC_OFS_SLAVE:  prdata[15:0] = {s.etp, s.ece, s.etps, s.etf, 1'b0, s.ts, 1'b0, s.sms};
      `TCC_OFS_OPTION: prdata[2:0] = {s.gateEn, s.extSel};
      `TCC_OFS_MODE:
      begin
        for (int i = 0; i < `TCC_NCH; i++)
          prdata[i*`TCC_MODE_STRIDE +: 11] = {s.ch[i].ocm, s.ch[i].icf, s.ch[i].icps,
                                              s.ch[i].dirSel};
      end
      `TCC_OFS_ENABLE:
      begin
        for (int i = 0; i < `TCC_NCH; i++)
          prdata[i*`TCC_ENA_STRIDE +: 2] = {s.ch[i].ccp, s.ch[i].cce};
      end
      `TCC_OFS_EVGEN:  prdata = 32'h0;
      `TCC_OFS_FLAG:
      begin
        for (int i = 0; i < `TCC_NCH; i++)
          prdata[`TCC_FLAG_BASE + i] = s.ch[i].flag;
      end
      `TCC_OFS_MISS:
      begin
        for (int i = 0; i < `TCC_NCH; i++)
          prdata[`TCC_FLAG_BASE + i] = s.ch[i].miss;
      end
      `TCC_OFS_IRQEN:
      begin
        for (int i = 0; i < `TCC_NCH; i++)
          prdata[`TCC_FLAG_BASE + i] = s.ch[i].ie;
      end
      `TCC_OFS_CCR0:   prdata[`TCC_CNT_W-1:0] = s.ch[0].ccr;
      `TCC_OFS_CCR1:   prdata[`TCC_CNT_W-1:0] = s.ch[1].ccr;
      `TCC_OFS_COUNT:  prdata[`TCC_CNT_W-1:0] = s.cnt;
      default:         pslverr = psel & penable;
    endcase
  end

  // next-state logic for the whole block
  always_comb
  begin
    logic etrIn;
    logic capPulse;
    logic setFlag;
    logic clrFlag;
    logic [7:0] ccrOfs;
    etrIn    = 1'b0;
    capPulse = 1'b0;
    setFlag  = 1'b0;
    clrFlag  = 1'b0;
    ccrOfs   = 8'h0;
    next_s   = s;
    next_s.pclkDiv = ~s.pclkDiv;

    // external trigger: polarity, filter, prescaler
    etrIn = etrRaw ^ s.etp;
    if (etrIn == s.etrFilt)
      next_s.etrFcnt = 4'h0;
    else if (s.etrFcnt >= filtLim(s.etf))
    begin
      next_s.etrFilt = etrIn;
      next_s.etrFcnt = 4'h0;
    end
    else
      next_s.etrFcnt = s.etrFcnt + 4'h1;
    next_s.etrPrev = s.etrFilt;
    if (s.etrFilt & ~s.etrPrev)
    begin
      // one toggle per full prescaler period
      if (s.etrPsc >= pscLim(s.etps))
      begin
        next_s.etrPsc  = 3'h0;
        next_s.etrpTog = ~s.etrpTog;
      end
      else
        next_s.etrPsc = s.etrPsc + 3'h1;
    end
    // two-flop crossing of the prescaled trigger
    next_s.sync1  = s.etrpTog;
    next_s.sync2  = s.sync1;
    next_s.sync2d = s.sync2;

    // counter: reset mode wins over counting
    if ((s.sms == `TCC_SMS_RESET) & trig)
      next_s.cnt = '0;
    else if (s.cen & (~s.ece | etrTick))
      next_s.cnt = s.cnt + 1'b1;

    // register writes
    if (wrEn)
    begin
      unique case (paddr)
        `TCC_OFS_CTRL:   next_s.cen = pwdata[0];
        `TCC_OFS_SLAVE:
        begin
          next_s.sms  = pwdata[2:0];
          next_s.ts   = pwdata[6:4];
          next_s.etf  = pwdata[11:8];
          next_s.etps = pwdata[13:12];
          next_s.ece  = pwdata[14];
          next_s.etp  = pwdata[15];
        end
        `TCC_OFS_OPTION:
        begin
          next_s.extSel = pwdata[1:0];
          next_s.gateEn = pwdata[2];
        end
        default: ;
      endcase
    end

    for (int i = 0; i < `TCC_NCH; i++)
    begin
      ccrOfs = (i == 0) ? `TCC_OFS_CCR0 : `TCC_OFS_CCR1;
      // input filter on the selected pin
      if (chRaw[i] == s.ch[i].filt)
        next_s.ch[i].fcnt = 4'h0;
      else if (s.ch[i].fcnt >= filtLim(s.ch[i].icf))
      begin
        next_s.ch[i].filt = chRaw[i];
        next_s.ch[i].fcnt = 4'h0;
      end
      else
        next_s.ch[i].fcnt = s.ch[i].fcnt + 4'h1;
      next_s.ch[i].prevF = s.ch[i].filt;

      capPulse = 1'b0;
      setFlag  = 1'b0;
      if (s.ch[i].dirSel != `TCC_DIR_OUT)
      begin
        // capture prescaler, counts only enabled edges
        if (chEdge[i] & s.ch[i].cce)
        begin
          if (s.ch[i].psc >= pscLim(s.ch[i].icps))
          begin
            next_s.ch[i].psc = 3'h0;
            capPulse = 1'b1;
          end
          else
            next_s.ch[i].psc = s.ch[i].psc + 3'h1;
        end
        next_s.ch[i].capPend = capPulse;
        if (capPulse)
          next_s.ch[i].shadow = s.cnt;
        if (s.ch[i].capPend)
        begin
          next_s.ch[i].ccr = s.ch[i].shadow;
          setFlag = 1'b1;
          if (s.ch[i].flag)
            next_s.ch[i].miss = 1'b1;
        end
      end
      else
      begin
        // compare path; forced levels do not stop matching
        next_s.ch[i].capPend = 1'b0;
        next_s.ch[i].psc     = 3'h0;
        next_s.ch[i].shadow  = s.ch[i].ccr;
        if (s.ch[i].shadow == s.cnt)
          setFlag = 1'b1;
        if (s.ch[i].ocm == `TCC_OCM_HIGH)
          next_s.ch[i].outRef = 1'b1;
        else if (s.ch[i].ocm == `TCC_OCM_LOW)
          next_s.ch[i].outRef = 1'b0;
      end

      // software clears; hardware set below wins
      clrFlag = (wrEn & (paddr == `TCC_OFS_FLAG) & pwdata[`TCC_FLAG_BASE + i]) |
                (rdEn & (paddr == ccrOfs));
      if (wrEn & (paddr == `TCC_OFS_EVGEN) & pwdata[`TCC_FLAG_BASE + i])
        setFlag = 1'b1;
      if (clrFlag)
        next_s.ch[i].flag = 1'b0;
      if (setFlag)
        next_s.ch[i].flag = 1'b1;
      if (wrEn & (paddr == `TCC_OFS_MISS) & pwdata[`TCC_FLAG_BASE + i] &
          ~(s.ch[i].capPend & s.ch[i].flag))
        next_s.ch[i].miss = 1'b0;

      // configuration writes
      if (wrEn & (paddr == `TCC_OFS_MODE))
      begin
        next_s.ch[i].dirSel = pwdata[i*`TCC_MODE_STRIDE +: 2];
        next_s.ch[i].icps   = pwdata[i*`TCC_MODE_STRIDE + 2 +: 2];
        next_s.ch[i].icf    = pwdata[i*`TCC_MODE_STRIDE + 4 +: 4];
        next_s.ch[i].ocm    = pwdata[i*`TCC_MODE_STRIDE + 8 +: 3];
      end
      if (wrEn & (paddr == `TCC_OFS_ENABLE))
      begin
        next_s.ch[i].cce = pwdata[i*`TCC_ENA_STRIDE];
        next_s.ch[i].ccp = pwdata[i*`TCC_ENA_STRIDE + 1];
      end
      if (wrEn & (paddr == `TCC_OFS_IRQEN))
        next_s.ch[i].ie = pwdata[`TCC_FLAG_BASE + i];
      // value writable only in output direction
      if (wrEn & (paddr == ccrOfs) & (s.ch[i].dirSel == `TCC_DIR_OUT))
        next_s.ch[i].ccr = pwdata[`TCC_CNT_W-1:0];
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // eight equal samples at the new level
  sequence highRun8_q;
    (chRaw[0] && !s.ch[0].filt && s.ch[0].icf == `TCC_FILT_8)[*8];
  endsequence
  // a capture lands while the flag is up
  sequence capOnFlag_q;
    s.ch[0].capPend && s.ch[0].flag;
  endsequence

  filt_eight_a: assert property (highRun8_q |=> s.ch[0].filt)
    else $error("filter did not follow after eight samples");
  filt_early_a: assert property ((s.ch[0].icf == `TCC_FILT_8 && !s.ch[0].filt &&
                                  s.ch[0].fcnt < 4'h7) |=> !s.ch[0].filt)
    else $error("filter switched too early");
  cap_copy_a: assert property (s.ch[0].capPend |=> s.ch[0].ccr == $past(s.ch[0].shadow)
                               && s.ch[0].flag)
    else $error("capture not copied to buffer with flag");
  cap_miss_a: assert property (capOnFlag_q |=> s.ch[0].miss)
    else $error("missed capture not flagged");
  irq_gate_a: assert property (ccIrq[1] == (s.ch[1].flag && s.ch[1].ie))
    else $error("interrupt not gated by enable");
  ccr_ro_a: assert property ((wrEn && paddr == `TCC_OFS_CCR0 && s.ch[0].dirSel != 2'h0
                              && !s.ch[0].capPend) |=> $stable(s.ch[0].ccr))
    else $error("input channel value was overwritten");
  force_out_a: assert property ((s.ch[0].dirSel == 2'h0 && s.ch[0].ocm == 3'h5 &&
                                 !s.ch[0].ccp) [*2] |-> channelOutput[0])
    else $error("forced high not seen on output");
  slave_rst_a: assert property ((s.sms == 3'h4 && trig) |=> s.cnt == '0)
    else $error("slave reset did not clear counter");
  rd_clear_a: assert property ((rdEn && paddr == `TCC_OFS_CCR1 && !s.ch[1].capPend &&
                                !(wrEn) && s.ch[1].dirSel != 2'h0) |=> !s.ch[1].flag)
    else $error("read of value did not clear flag");
endmodule : tcc_timer_channels

/* File: include/tcc_defs.svh */
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// register byte offsets
`define TCC_OFS_CTRL    8'h00
`define TCC_OFS_SLAVE   8'h04
`define TCC_OFS_OPTION  8'h08
`define TCC_OFS_MODE    8'h0c
`define TCC_OFS_ENABLE  8'h10
`define TCC_OFS_EVGEN   8'h14
`define TCC_OFS_FLAG    8'h18
`define TCC_OFS_MISS    8'h1c
`define TCC_OFS_IRQEN   8'h20
`define TCC_OFS_CCR0    8'h24
`define TCC_OFS_CCR1    8'h28
`define TCC_OFS_COUNT   8'h2c
// field positions
`define TCC_CNT_W       16
`define TCC_NCH         2
`define TCC_MODE_STRIDE 16
`define TCC_ENA_STRIDE  4
`define TCC_FLAG_BASE   1
// encodings
`define TCC_DIR_OUT     2'h0
`define TCC_DIR_OWN     2'h1
`define TCC_DIR_NEIGH   2'h2
`define TCC_SRC_PCLK    2'h0
`define TCC_SRC_1K      2'h1
`define TCC_SRC_32K     2'h2
`define TCC_SRC_PIN     2'h3
`define TCC_OCM_LOW     3'h4
`define TCC_OCM_HIGH    3'h5
`define TCC_SMS_RESET   3'h4
`define TCC_TS_CH0      3'h5
`define TCC_TS_CH1      3'h6
`define TCC_FILT_NONE   4'h0
`define TCC_FILT_8      4'h3
`endif

/* File: include/tcc_pkg.sv */
`include "tcc_defs.svh"
package tcc_pkg;
  // per-channel configuration and state
  typedef struct packed {
    logic [1:0]               dirSel;   // channel_direction_select
    logic [1:0]               icps;     // input_prescaler_setting
    logic [3:0]               icf;      // input_filter_setting
    logic [2:0]               ocm;      // output_mode_field
    logic                     cce;      // channel_enable_bit
    logic                     ccp;      // channel_polarity_bit
    logic                     ie;       // interrupt enable
    logic [`TCC_CNT_W-1:0]    ccr;      // buffer, software view
    logic [`TCC_CNT_W-1:0]    shadow;   // capture / compare shadow
    logic                     filt;     // filtered_channel_input
    logic [3:0]               fcnt;     // filter run length
    logic                     prevF;    // last filtered level
    logic [2:0]               psc;      // capture prescaler count
    logic                     capPend;  // shadow loaded, copy due
    logic                     outRef;   // output_reference
    logic                     flag;     // channel_event_flag
    logic                     miss;     // missed_capture_flag
  } tcc_ch_s;
  // whole module state
  typedef struct packed {
    logic                     cen;      // counter_enable_bit
    logic [2:0]               sms;      // slave_mode_select
    logic [2:0]               ts;       // trigger_select
    logic [3:0]               etf;      // ext_trigger_filter
    logic [1:0]               etps;     // ext_trigger_prescaler
    logic                     ece;      // ext_clock_mode2_enable
    logic                     etp;      // ext_trigger_polarity
    logic [1:0]               extSel;   // ext_trigger_source_select
    logic                     gateEn;   // clock_gate_enable
    logic                     pclkDiv;  // pclk-derived trigger source
    logic                     etrFilt;
    logic [3:0]               etrFcnt;
    logic                     etrPrev;
    logic [2:0]               etrPsc;
    logic                     etrpTog;  // prescaled_ext_trigger as toggle
    logic                     sync1;
    logic                     sync2;
    logic                     sync2d;
    logic [`TCC_CNT_W-1:0]    cnt;
    tcc_ch_s [`TCC_NCH-1:0]   ch;
  } tcc_state_s;
endpackage : tcc_pkg

/* File: tb/tcc_pin_model.sv */
`timescale 1ns/1ps
`include "tcc_defs.svh"
// far-side pins: channel inputs, trigger pin, gate pin, slow clocks
module tcc_pin_model
(
  input  wire logic                mclk,
  output logic                     clk1kIn,
  output logic                     clk32kIn,
  output logic                     timerClockPin,
  output logic                     timerClockGatePin,
  output logic [`TCC_NCH-1:0]      channelInputPin
);
  int unsigned div;                // slow-clock divider
  // all pins idle low until a scenario moves them; slow clocks until their divider does
  initial
  begin
    clk1kIn = 1'b0;
    clk32kIn = 1'b0;
    timerClockPin = 1'b0;
    timerClockGatePin = 1'b0;
    channelInputPin = '0;
    div = 0;
  end
  // slow clocks run free; half periods in mclk cycles, not exact rates
  always @(posedge mclk)
  begin
    div <= div + 1;
    if (div % 312 == 311)
      clk32kIn <= ~clk32kIn;
    if (div % 1000 == 999)
      clk1kIn <= ~clk1kIn;
  end
  // pin moves always land just after a rising edge
  task automatic set_ch(input int c, input logic v);
    @(posedge mclk);
    channelInputPin[c] <= v;
  endtask : set_ch
  task automatic set_etr(input logic v);
    @(posedge mclk);
    timerClockPin <= v;
  endtask : set_etr
  task automatic set_gate(input logic v);
    @(posedge mclk);
    timerClockGatePin <= v;
  endtask : set_gate
  // clean pulses, 6 cycles high and 6 low, wider than the synchroniser
  task automatic etr_pulse(input int n);
    repeat (n)
    begin
      set_etr(1'b1);
      repeat (5) @(posedge mclk);
      set_etr(1'b0);
      repeat (5) @(posedge mclk);
    end
  endtask : etr_pulse
  // n periods of a pwm wave on channel pin 0, rising first
  task automatic pwm(input int n, input int hi, input int lo);
    repeat (n)
    begin
      set_ch(0, 1'b1);
      repeat (hi - 1) @(posedge mclk);
      set_ch(0, 1'b0);
      repeat (lo - 1) @(posedge mclk);
    end
  endtask : pwm
endmodule : tcc_pin_model

/* File: tb/timer_capture_compare_channels_tb_top.sv */
`timescale 1ns/1ps
`include "tcc_defs.svh"
`define CHK(nm, e, g) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
      errCount++; \
    end \
  end
// bench top: apb master, pin partner, one task per scenario
module timer_capture_compare_channels_tb_top;
  import tcc_pkg::*;
  logic                   mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rdat;
  logic                   rerr;      // last read error
  logic                   clk1kIn, clk32kIn, timerClockPin, timerClockGatePin;
  logic [`TCC_NCH-1:0]    channelInputPin, channelOutput, channelOutputEn, ccIrq;
  logic [`TCC_CNT_W-1:0]  counterValue, cv;
  int                     errCount, samplesChecked;

  tcc_timer_channels DUT (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk1kIn(clk1kIn), .clk32kIn(clk32kIn),
    .timerClockPin(timerClockPin), .timerClockGatePin(timerClockGatePin),
    .channelInputPin(channelInputPin), .channelOutput(channelOutput),
    .channelOutputEn(channelOutputEn), .ccIrq(ccIrq), .counterValue(counterValue));
  tcc_pin_model pins (.mclk(mclk), .clk1kIn(clk1kIn), .clk32kIn(clk32kIn),
    .timerClockPin(timerClockPin), .timerClockGatePin(timerClockGatePin),
    .channelInputPin(channelInputPin));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // state commits at the access edge, outputs follow a cycle later
    repeat (2) @(posedge mclk);
  endtask : wr
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask : expect_rd

  // reset values and a refused address
  task automatic t_reset;
    `CHK("pready", 1'b1, pready)
    `CHK("outputs", 6'h00, {channelOutput, channelOutputEn, ccIrq})
    expect_rd(`TCC_OFS_COUNT, 32'h0, "count");
    expect_rd(8'h30, 32'h0, "unmapped");
    `CHK("pslverr", 1'b1, rerr)
  endtask : t_reset
  // external clock mode 2: pin source, prescaler 01, gate, 32k source
  task automatic t_extclk;
    wr(`TCC_OFS_OPTION, 32'h3);
    wr(`TCC_OFS_SLAVE, 32'h5000);
    wr(`TCC_OFS_CTRL, 32'h1);
    pins.etr_pulse(7);
    repeat (10) @(posedge mclk);
    `CHK("count", 16'h3, counterValue)
    pins.set_etr(1'b1);
    @(posedge mclk);
    `CHK("count_lag", 16'h3, counterValue)
    repeat (10) @(posedge mclk);
    `CHK("count", 16'h4, counterValue)
    pins.set_etr(1'b0);
    wr(`TCC_OFS_OPTION, 32'h7);
    pins.etr_pulse(4);
    `CHK("gated", 16'h4, counterValue)
    pins.set_gate(1'b1);
    pins.etr_pulse(2);
    repeat (10) @(posedge mclk);
    `CHK("ungated", 16'h5, counterValue)
    wr(`TCC_OFS_OPTION, 32'h2);
    repeat (2600) @(posedge mclk);
    `CHK("slow_clock", 1'b1, counterValue >= 16'h7)
    wr(`TCC_OFS_SLAVE, 32'h0);
  endtask : t_extclk
  // capture on channel 0 with 8-sample filter, flags, miss, read-only
  task automatic t_capture;
    wr(`TCC_OFS_MODE, 32'h31);
    wr(`TCC_OFS_ENABLE, 32'h1);
    wr(`TCC_OFS_IRQEN, 32'h2);
    // compare matches at counter zero left both flags set since reset
    wr(`TCC_OFS_FLAG, 32'h6);
    pins.set_ch(0, 1'b1);
    repeat (5) @(posedge mclk);
    pins.set_ch(0, 1'b0);
    repeat (15) @(posedge mclk);
    expect_rd(`TCC_OFS_FLAG, 32'h0, "glitch_flag");
    pins.set_ch(0, 1'b1);
    repeat (20) @(posedge mclk);
    `CHK("irq", 2'b01, ccIrq)
    pins.set_ch(0, 1'b0);
    repeat (12) @(posedge mclk);
    pins.set_ch(0, 1'b1);
    cv = counterValue;
    repeat (20) @(posedge mclk);
    expect_rd(`TCC_OFS_MISS, 32'h2, "miss");
    apb(1'b0, `TCC_OFS_CCR0, 32'h0);
    `CHK("capture", 1'b1, (rdat[15:0] - cv) inside {[16'd6:16'd20]})
    cv = rdat[15:0];
    expect_rd(`TCC_OFS_FLAG, 32'h0, "flag_read_clear");
    `CHK("irq_off", 2'b00, ccIrq)
    expect_rd(`TCC_OFS_MISS, 32'h2, "miss_kept");
    wr(`TCC_OFS_MISS, 32'h2);
    expect_rd(`TCC_OFS_MISS, 32'h0, "miss_clear");
    wr(`TCC_OFS_CCR0, 32'h1234);
    expect_rd(`TCC_OFS_CCR0, {16'h0, cv}, "ccr_ro");
    wr(`TCC_OFS_ENABLE, 32'h3);
    pins.set_ch(0, 1'b0);
    repeat (20) @(posedge mclk);
    expect_rd(`TCC_OFS_FLAG, 32'h2, "fall_flag");
    wr(`TCC_OFS_FLAG, 32'h2);
    pins.set_ch(0, 1'b1);
    repeat (20) @(posedge mclk);
    expect_rd(`TCC_OFS_FLAG, 32'h0, "rise_ignored");
    wr(`TCC_OFS_ENABLE, 32'h2);
    pins.set_ch(0, 1'b0);
    repeat (20) @(posedge mclk);
    expect_rd(`TCC_OFS_FLAG, 32'h0, "capture_off");
  endtask : t_capture
  // pwm input: ch0 period on own pin, ch1 duty on neighbour pin
  task automatic t_pwmin;
    wr(`TCC_OFS_MODE, 32'h0002_0001);
    wr(`TCC_OFS_ENABLE, 32'h31);
    wr(`TCC_OFS_SLAVE, 32'h54);
    pins.pwm(3, 20, 40);
    apb(1'b0, `TCC_OFS_CCR0, 32'h0);
    `CHK("period", 1'b1, rdat[15:0] inside {[16'd55:16'd64]})
    apb(1'b0, `TCC_OFS_CCR1, 32'h0);
    `CHK("duty", 1'b1, rdat[15:0] inside {[16'd16:16'd24]})
    wr(`TCC_OFS_SLAVE, 32'h0);
  endtask : t_pwmin
  // software flag event on channel 1, no capture copied
  task automatic t_evgen;
    wr(`TCC_OFS_FLAG, 32'h6);
    wr(`TCC_OFS_IRQEN, 32'h4);
    wr(`TCC_OFS_EVGEN, 32'h4);
    expect_rd(`TCC_OFS_FLAG, 32'h4, "evgen_flag");
    `CHK("evgen_irq", 2'b10, ccIrq)
    wr(`TCC_OFS_FLAG, 32'h4);
  endtask : t_evgen
  // forced levels, polarity, compare still flags
  task automatic t_forced;
    wr(`TCC_OFS_MODE, 32'h500);
    wr(`TCC_OFS_ENABLE, 32'h1);
    `CHK("forced_high", 2'b11, {channelOutput[0], channelOutputEn[0]})
    wr(`TCC_OFS_ENABLE, 32'h3);
    `CHK("inverted", 1'b0, channelOutput[0])
    wr(`TCC_OFS_MODE, 32'h400);
    `CHK("forced_low_inv", 1'b1, channelOutput[0])
    wr(`TCC_OFS_ENABLE, 32'h1);
    `CHK("forced_low", 1'b0, channelOutput[0])
    wr(`TCC_OFS_IRQEN, 32'h6);
    cv = counterValue + 16'd40;
    wr(`TCC_OFS_CCR0, {16'h0, cv});
    wr(`TCC_OFS_FLAG, 32'h6);
    expect_rd(`TCC_OFS_CCR0, {16'h0, cv}, "ccr_buffer");
    repeat (60) @(posedge mclk);
    `CHK("compare_irq", 2'b01, ccIrq)
    `CHK("still_low", 1'b0, channelOutput[0])
  endtask : t_forced
  // halved-clock and slow sources, channel 1 on its own pin
  task automatic t_sources;
    wr(`TCC_OFS_SLAVE, 32'h4000);
    wr(`TCC_OFS_OPTION, 32'h0);
    cv = counterValue;
    repeat (40) @(posedge mclk);
    `CHK("pclk_rate", 1'b1, (counterValue - cv) inside {[16'd16:16'd21]})
    wr(`TCC_OFS_OPTION, 32'h1);
    cv = counterValue;
    repeat (2100) @(posedge mclk);
    `CHK("slow_1k", 1'b1, (counterValue - cv) inside {[16'd1:16'd3]})
    wr(`TCC_OFS_MODE, 32'h0001_0000);
    wr(`TCC_OFS_ENABLE, 32'h10);
    wr(`TCC_OFS_FLAG, 32'h6);
    pins.set_ch(1, 1'b1);
    repeat (10) @(posedge mclk);
    expect_rd(`TCC_OFS_FLAG, 32'h4, "own_pin_flag");
  endtask : t_sources

  // verdict and end of run
  task automatic results;
    if (errCount == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // watchdog, about three and a half times the expected run
  initial
  begin
    repeat (20000) @(posedge mclk);
    errCount++;
    results();
  end
  // main sequence
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errCount = 0;
    samplesChecked = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_extclk();
    t_capture();
    t_pwmin();
    t_evgen();
    t_forced();
    t_sources();
    results();
  end
endmodule : timer_capture_compare_channels_tb_top
